// ===== core/sadc_host.sv
// host end: divides system clock, shifts 24-clock slots, pulses latch strobe
`timescale 1ns/1ps
`include "sadc_defines.svh"
module sadc_host (
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_in,
  input  wire sadc_pkg::sadc_sample_t  sample_in,
  input  wire logic                    sample_valid_in,
  output logic                         sample_ready_out,
  output logic                         busy_out,
  sadc_link_if.host                    link
);
  localparam int LINK_KHZ = `SADC_SYS_CLK_KHZ / (2 * `SADC_DIV_HALF);

  typedef struct packed {
    sadc_pkg::sadc_host_state_t state;
    logic [`SADC_DIV_W-1:0]     div;
    logic                       clk;
    logic [`SADC_SLOT_W-1:0]    bit_cnt;
    logic [23:0]                slot;
    logic                       data;
    logic                       strobe;
  } sadc_host_st_t;

  sadc_host_st_t st_q;
  sadc_host_st_t st_d;
  logic          fall;

  always_comb begin
    st_d = st_q;
    fall = 1'b0;
    if (st_q.state != sadc_pkg::SADC_IDLE) begin
      if (st_q.div == `SADC_DIV_HALF - 4'h1) begin
        st_d.div = '0;
        st_d.clk = ~st_q.clk;
        fall     = st_q.clk;
      end else begin
        st_d.div = st_q.div + 4'h1;
      end
    end
    case (st_q.state)
      sadc_pkg::SADC_IDLE: begin
        st_d.clk = 1'b0;
        st_d.div = '0;
        if (sample_valid_in) begin
          // 6 pad bits then 18 msb first
          st_d.slot    = {6'h00, sample_in};
          st_d.data    = 1'b0;
          st_d.bit_cnt = '0;
          st_d.state   = sadc_pkg::SADC_SHIFT;
        end
      end
      sadc_pkg::SADC_SHIFT: begin
        // data changes on falling edge, stable for rising sample
        if (fall) begin
          if (st_q.bit_cnt == 5'(`SADC_SLOT_BITS - 1)) begin
            // park data low so it only ever moves on a falling edge
            st_d.data   = 1'b0;
            st_d.strobe = 1'b0;
            st_d.state  = sadc_pkg::SADC_STROBE;
          end else begin
            // bit 23 went out before the first rise, so the next bit follows
            st_d.slot    = {st_q.slot[22:0], 1'b0};
            st_d.data    = st_q.slot[22];
            st_d.bit_cnt = st_q.bit_cnt + 5'h01;
            // strobe up only after first rise
            st_d.strobe  = 1'b1;
          end
        end
      end
      sadc_pkg::SADC_STROBE: begin
        if (fall) begin
          st_d.state = sadc_pkg::SADC_HOLD;
        end
      end
      sadc_pkg::SADC_HOLD: begin
        if (fall) begin
          st_d.state = sadc_pkg::SADC_IDLE;
        end
      end
      default: st_d.state = sadc_pkg::SADC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // first rising edge of a word precedes strobe rising, so strobe stays low
  assign link.link_clk          = st_q.clk;
  assign link.serial_data       = st_q.data;
  assign link.word_latch_strobe = st_q.strobe;
  assign sample_ready_out       = (st_q.state == sadc_pkg::SADC_IDLE);
  assign busy_out               = (st_q.state != sadc_pkg::SADC_IDLE) && (LINK_KHZ > 0);
endmodule

// ===== core/sadc_defines.svh
// constants shared by both ends of the serial audio converter link
// Overview of operation
// - sample word is 18-bit two's complement
// - data bit sampled on rising link clock
// - host holds strobe low two full clocks
// - clock stopped: strobe low past next first clock
// - codes map to full scale and bipolar zero
// - host link clock at most 16.9 MHz
// - 24-clock slot, only 18 bits used
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH
`define SADC_WORD_BITS      18
`define SADC_SLOT_BITS      24
`define SADC_SLOT_W         5
`define SADC_MSB            17
`define SADC_POS_FULL_SCALE 18'h1FFFF
`define SADC_BIPOLAR_ZERO   18'h00000
`define SADC_ZERO_MINUS_ONE 18'h3FFFF
`define SADC_NEG_FULL_SCALE 18'h20000
`define SADC_LINK_MAX_KHZ   16900
`define SADC_SYS_CLK_KHZ    10000
`define SADC_DIV_HALF       4'h2
`define SADC_DIV_W          4
`endif

// ===== core/sadc_pkg.sv
// types shared by both ends of the serial audio converter link
package sadc_pkg;
  typedef logic [17:0] sadc_sample_t;
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SHIFT,
    SADC_STROBE,
    SADC_HOLD
  } sadc_host_state_t;
  typedef enum logic [1:0] {
    SADC_ZERO,
    SADC_POSITIVE,
    SADC_NEGATIVE,
    SADC_NEG_FULL
  } sadc_level_t;
endpackage

// ===== core/sadc_link_if.sv
// serial link wires between host and converter input
`timescale 1ns/1ps
interface sadc_link_if;
  logic link_clk;
  logic serial_data;
  logic word_latch_strobe;
  modport host (
    output link_clk,
    output serial_data,
    output word_latch_strobe
  );
  modport device (
    input link_clk,
    input serial_data,
    input word_latch_strobe
  );
endinterface

// ===== core/sadc_device.sv
// converter input end: shift register and output latch on the link clock
`timescale 1ns/1ps
`include "sadc_defines.svh"
module sadc_device (
  sadc_link_if.device           link,
  input  wire logic             rst_in,
  output sadc_pkg::sadc_sample_t dac_code_out,
  output sadc_pkg::sadc_level_t  dac_level_out,
  output logic                   word_valid_out
);
  typedef struct packed {
    logic [17:0]           shift;
    logic                  strobe_prev;
    sadc_pkg::sadc_sample_t code;
    sadc_pkg::sadc_level_t  level;
    logic                  valid;
  } sadc_dev_state_t;

  sadc_dev_state_t st_q;
  sadc_dev_state_t st_d;
  logic            rst_meta_q;
  logic            rst_sync_q;

  // reset is from the system domain, so it is resynchronised here
  always_ff @(posedge link.link_clk) begin
    rst_meta_q <= rst_in;
    rst_sync_q <= rst_meta_q;
  end

  always_comb begin
    st_d = st_q;
    st_d.strobe_prev = link.word_latch_strobe;
    // msb first shift
    // longer slots just push extra bits through; only the last 18 stay
    st_d.shift = {st_q.shift[`SADC_MSB-1:0], link.serial_data};
    st_d.valid = 1'b0;
    if (st_q.strobe_prev && !link.word_latch_strobe) begin
      st_d.code  = st_q.shift;
      st_d.valid = 1'b1;
      if (st_q.shift == `SADC_BIPOLAR_ZERO) begin
        st_d.level = sadc_pkg::SADC_ZERO;
      end else if (st_q.shift == `SADC_NEG_FULL_SCALE) begin
        st_d.level = sadc_pkg::SADC_NEG_FULL;
      end else if (st_q.shift[`SADC_MSB]) begin
        st_d.level = sadc_pkg::SADC_NEGATIVE;
      end else begin
        st_d.level = sadc_pkg::SADC_POSITIVE;
      end
    end
  end

  always_ff @(posedge link.link_clk) begin
    if (rst_sync_q) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dac_code_out   = st_q.code;
  assign dac_level_out  = st_q.level;
  assign word_valid_out = st_q.valid;
endmodule

// ===== tb/sadc_link_props.sv
// assertions on the serial link wires
`timescale 1ns/1ps
module sadc_link_props (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic link_clk,
  input wire logic serial_data,
  input wire logic word_latch_strobe
);
  logic [4:0] rise_q;
  logic [2:0] low_q;
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  // three low samples in a row only happen once the clock has stopped
  always_ff @(posedge sys_clk_in)
    low_q <= (rst_in || link_clk) ? 3'h0 : low_q + 3'(low_q != 3'h7);
  // link rises since the clock restarted; trailing strobe clocks do not leak over
  always_ff @(posedge sys_clk_in)
    rise_q <= ((rst_in || low_q >= 3'h3) ? 5'h00 : rise_q) + 5'($rose(link_clk));
  a_data_rise: assert property ($rose(link_clk) |-> $stable(serial_data))
    else $error("data moved at clock rise");
  a_data_fall: assert property ($changed(serial_data) |-> $fell(link_clk))
    else $error("data moved off clock fall");
  a_strobe_hold: assert property ($fell(word_latch_strobe) |-> !word_latch_strobe [*8])
    else $error("strobe low too short");
  a_stop_low: assert property (!link_clk [*5] |-> !word_latch_strobe)
    else $error("strobe high with clock stopped");
  a_strobe_rise: assert property ($rose(word_latch_strobe) |-> rise_q == 5'h01)
    else $error("strobe rose before first clock");
  a_high_min: assert property ($rose(link_clk) |-> link_clk [*2])
    else $error("clock high too short");
  a_low_min: assert property ($fell(link_clk) |-> !link_clk [*2])
    else $error("clock low too short");
  a_slot_len: assert property ($fell(word_latch_strobe) |-> rise_q == 5'h18)
    else $error("slot not 24 clocks");
endmodule

// ===== tb/serial_audio_dac_input_tb.sv
// bench joining host and converter ends over the link
`timescale 1ns/1ps
`include "sadc_defines.svh"
module serial_audio_dac_input_tb;
  logic                   sys_clk_in = 1'b0;
  logic                   rst_in = 1'b1;
  logic                   dev_rst = 1'b1;
  sadc_pkg::sadc_sample_t sample_in = 18'h00000;
  logic                   sample_valid_in = 1'b0;
  logic                   sample_ready_out;
  logic                   busy_out;
  sadc_pkg::sadc_sample_t dac_code_out;
  sadc_pkg::sadc_level_t  dac_level_out;
  logic                   word_valid_out;
  int                     latch_count = 0;
  int                     err_count = 0;
  int                     cmp_count = 0;
  sadc_link_if link_if ();
  sadc_host u_sadc_host (.sys_clk_in, .rst_in, .sample_in, .sample_valid_in,
    .sample_ready_out, .busy_out, .link(link_if));
  sadc_device u_sadc_device (.link(link_if), .rst_in(dev_rst), .dac_code_out,
    .dac_level_out, .word_valid_out);
  sadc_link_props u_sadc_link_props (.sys_clk_in, .rst_in, .link_clk(link_if.link_clk),
    .serial_data(link_if.serial_data), .word_latch_strobe(link_if.word_latch_strobe));
  always #50 sys_clk_in = ~sys_clk_in;
  // valid stands one link period; the falling edge sees it settled
  always @(negedge link_if.link_clk) begin
    if (word_valid_out === 1'b1) latch_count <= latch_count + 1;
  end
  task check(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (err_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // busy rises in the same cycle as the take, yet wait at least three edges
  task send(input sadc_pkg::sadc_sample_t v);
    int n;
    n = 0;
    @(posedge sys_clk_in);
    sample_in       <= v;
    sample_valid_in <= 1'b1;
    #1;
    check({17'h00000, sample_ready_out}, 18'h00001);
    @(posedge sys_clk_in);
    sample_valid_in <= 1'b0;
    #1;
    check({17'h00000, sample_ready_out}, 18'h00000);
    do begin
      @(posedge sys_clk_in);
      #1;
      n++;
    end while ((busy_out !== 1'b0 || n < 3) && n < 400);
  endtask
  function automatic logic [17:0] lvl(input logic [17:0] c);
    if (c == `SADC_BIPOLAR_ZERO) return 18'h00000;
    if (c == `SADC_NEG_FULL_SCALE) return 18'h00003;
    return c[17] ? 18'h00002 : 18'h00001;
  endfunction
  // the word latches on the rise after the strobe falls, before the clock stops
  task automatic send_check(input sadc_pkg::sadc_sample_t v);
    int seen;
    seen = latch_count;
    send(v);
    check(dac_code_out, v);
    check({16'h0000, dac_level_out}, lvl(v));
    check(18'(latch_count - seen), 18'h00001);
  endtask
  task test_code_map;
    send_check(`SADC_POS_FULL_SCALE);
    send_check(`SADC_BIPOLAR_ZERO);
    send_check(`SADC_ZERO_MINUS_ONE);
    send_check(`SADC_NEG_FULL_SCALE);
  endtask
  // alternating bits catch a reversed or shifted word
  task test_bit_order;
    send_check(18'h2AAAA);
    send_check(18'h15555);
    send_check(18'h00001);
  endtask
  // host reset lands in the strobe clocks: the latched word must survive the cut
  task automatic test_mid_reset;
    int seen;
    seen = latch_count;
    @(posedge sys_clk_in);
    sample_in       <= `SADC_ZERO_MINUS_ONE;
    sample_valid_in <= 1'b1;
    @(posedge sys_clk_in);
    sample_valid_in <= 1'b0;
    repeat (99) @(posedge sys_clk_in);
    rst_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    check({16'h0000, link_if.link_clk, link_if.word_latch_strobe}, 18'h00000);
    check(dac_code_out, `SADC_ZERO_MINUS_ONE);
    check({16'h0000, dac_level_out}, lvl(`SADC_ZERO_MINUS_ONE));
    check(18'(latch_count - seen), 18'h00001);
    send_check(18'h0F0F0);
  endtask
  initial begin
    repeat (16) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    // converter end needs link edges to leave reset
    send(18'h00000);
    @(posedge sys_clk_in);
    dev_rst <= 1'b0;
    test_code_map;
    test_bit_order;
    test_mid_reset;
    give_verdict;
  end
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    err_count++;
    give_verdict;
  end
endmodule
